/* logic/ppfm_pkg.sv */
`default_nettype none

package ppfm_pkg;

    // ---------------------------------------------------------------
    // Port widths
    // ---------------------------------------------------------------
    localparam int B_WIDTH = 8;
    localparam int C_WIDTH = 8;
    localparam int D_WIDTH = 3;

    // ---------------------------------------------------------------
    // Fixed pin positions of the dedicated functions
    // ---------------------------------------------------------------
    localparam int PC_TMS_POS = 0;
    localparam int PC_TCK_POS = 1;
    localparam int PC_STAT_POS = 3;
    localparam int PC_ERR_POS = 4;
    localparam int PC_TDI_POS = 5;
    localparam int PC_TDO_POS = 6;
    localparam int PD_CLK_POS = 1;
    localparam int PD_CSI_POS = 2;
    // Port B pins with slew control are 0..3, open-drain capable 3..7
    localparam int PB_SLEW_HI = 3;
    localparam int PB_OD_LO = 3;

    // ---------------------------------------------------------------
    // Reset values of configuration registers
    // ---------------------------------------------------------------
    localparam logic [1:0] PIN_FUNC_RST = 2'h0;
    localparam logic DATA_RST = 1'b0;
    localparam logic DIR_RST = 1'b0;
    localparam logic OD_RST = 1'b0;
    localparam logic SLEW_RST = 1'b0;

    // Per-pin function selection
    typedef enum logic [1:0] {
        PPFM_FN_GPIO = 2'h0,
        PPFM_FN_PLD_OUT = 2'h1,
        PPFM_FN_PLD_IN = 2'h2,
        PPFM_FN_SPECIAL = 2'h3
    } ppfm_func_t;

    // Resolved drive of one pin
    typedef struct packed {
        logic out;
        logic oe_n;
    } ppfm_drive_t;

    // Per-pin runtime I/O control
    typedef struct packed {
        logic data;
        logic dir;
        logic od;
    } ppfm_gpio_t;

endpackage : ppfm_pkg

`default_nettype wire

/* logic/ppfm_pin_cell.sv */
`default_nettype none

// Resolves one pin: picks its source, applies open drain, tri-states when idle
module ppfm_pin_cell (
    // Selected function and sources
    input wire ppfm_pkg::ppfm_func_t func_i,
    input wire ppfm_pkg::ppfm_gpio_t gpio_i,
    input wire logic pld_val_i,
    input wire logic pld_oe_i,
    input wire logic spc_val_i,
    input wire logic spc_oe_i,
    // Resolved drive
    output ppfm_pkg::ppfm_drive_t drive_o
);

    // Pin source selection, one function at a time
    always_comb begin
        logic val;
        logic en;
        val = 1'b0;
        en = 1'b0;
        case (func_i)
            ppfm_pkg::PPFM_FN_GPIO: begin
                val = gpio_i.data;
                en = gpio_i.dir;
            end
            ppfm_pkg::PPFM_FN_PLD_OUT: begin
                val = pld_val_i;
                en = pld_oe_i;
            end
            ppfm_pkg::PPFM_FN_SPECIAL: begin
                val = spc_val_i;
                en = spc_oe_i;
            end
            default: begin
                val = 1'b0;
                en = 1'b0;
            end
        endcase
        if (gpio_i.od && val) begin
            en = 1'b0;
        end
        drive_o.out = val;
        drive_o.oe_n = ~en;
    end

endmodule // ppfm_pin_cell

`default_nettype wire

/* logic/ppfm_top.sv */
// Notes on behaviour
// - Host reads and drives every port pin at runtime as general I/O.
// - Port B shows either macrocell group; port C only group two.
// - B and C pins feed input macrocells; D pins go straight to logic.
// - Port C bits 0,1,5,6 optionally carry test mode, clock, data in, out.
// - Port C bits 3,4 optionally carry test-port status and error.
// - Port C bit 3 optionally shows flash ready/busy for polling or interrupt.
// - Port C general I/O pins individually switch push-pull or open drain.
// - Port B 0-3 choose slew rate; bits 3-7 choose open drain.
// - Test-port functions share pins with other I/O when not selected.
// - Port D pins output chip-select terms without using a macrocell.
// - Port D bit 1 optionally feeds a common logic clock.
// - Port D bit 2 optionally is active-low flash select; high disables flash.
`default_nettype none

module ppfm_top #(
    parameter int B_PINS = ppfm_pkg::B_WIDTH,
    parameter int C_PINS = ppfm_pkg::C_WIDTH,
    parameter int D_PINS = ppfm_pkg::D_WIDTH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Pin function selection
    input wire ppfm_pkg::ppfm_func_t b_func_i [B_PINS],
    input wire ppfm_pkg::ppfm_func_t c_func_i [C_PINS],
    input wire ppfm_pkg::ppfm_func_t d_func_i [D_PINS],
    input wire logic [B_PINS-1:0] b_group_sel_i,
    input wire logic test_port_en_i,
    input wire logic test_port_ext_en_i,
    input wire logic ready_busy_en_i,
    input wire logic logic_clk_en_i,
    input wire logic flash_cs_en_i,
    // Host runtime I/O writes
    input wire logic [B_PINS-1:0] b_data_i,
    input wire logic [B_PINS-1:0] b_dir_i,
    input wire logic [B_PINS-1:0] b_od_i,
    input wire logic [B_PINS-1:0] b_fast_i,
    input wire logic [C_PINS-1:0] c_data_i,
    input wire logic [C_PINS-1:0] c_dir_i,
    input wire logic [C_PINS-1:0] c_od_i,
    input wire logic [D_PINS-1:0] d_data_i,
    input wire logic [D_PINS-1:0] d_dir_i,
    // Programmable logic sources
    input wire logic [B_PINS-1:0] macrocell_group_one_i,
    input wire logic [B_PINS-1:0] macrocell_group_one_oe_i,
    input wire logic [C_PINS-1:0] macrocell_group_two_i,
    input wire logic [C_PINS-1:0] macrocell_group_two_oe_i,
    input wire logic [D_PINS-1:0] ext_cs_term_i,
    input wire logic [D_PINS-1:0] ext_cs_oe_i,
    // Test port and flash status sources
    input wire logic test_data_out_i,
    input wire logic test_data_out_oe_i,
    input wire logic test_port_status_i,
    input wire logic test_port_error_i,
    input wire logic flash_busy_i,
    // Pin pads
    input wire logic [B_PINS-1:0] second_port_pins_i,
    output logic [B_PINS-1:0] second_port_pins_o,
    output logic [B_PINS-1:0] second_port_pins_oe_n_o,
    output logic [B_PINS-1:0] second_port_fast_o,
    input wire logic [C_PINS-1:0] third_port_pins_i,
    output logic [C_PINS-1:0] third_port_pins_o,
    output logic [C_PINS-1:0] third_port_pins_oe_n_o,
    input wire logic [D_PINS-1:0] fourth_port_pins_i,
    output logic [D_PINS-1:0] fourth_port_pins_o,
    output logic [D_PINS-1:0] fourth_port_pins_oe_n_o,
    // Readback and logic-side inputs
    output logic [B_PINS-1:0] b_read_o,
    output logic [C_PINS-1:0] c_read_o,
    output logic [D_PINS-1:0] d_read_o,
    output logic [B_PINS-1:0] b_input_mcell_o,
    output logic [C_PINS-1:0] c_input_mcell_o,
    output logic [D_PINS-1:0] d_logic_in_o,
    // Dedicated function inputs
    output logic test_mode_sel_o,
    output logic test_clk_o,
    output logic test_data_in_o,
    output logic logic_clock_input_o,
    output logic flash_cs_n_o,
    output logic flash_enable_o
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (B_PINS != ppfm_pkg::B_WIDTH || C_PINS != ppfm_pkg::C_WIDTH ||
        D_PINS != ppfm_pkg::D_WIDTH) begin : g_bad_width
        $error("Port widths are fixed by the dedicated pin positions");
    end

    // Is a port C pin taken by a dedicated function
    function automatic logic c_special(input int pos, input logic tp, input logic ext,
                                       input logic rb);
        logic r;
        r = 1'b0;
        if (tp && (pos == ppfm_pkg::PC_TMS_POS || pos == ppfm_pkg::PC_TCK_POS ||
                   pos == ppfm_pkg::PC_TDI_POS || pos == ppfm_pkg::PC_TDO_POS)) begin
            r = 1'b1;
        end
        if ((ext || rb) && pos == ppfm_pkg::PC_STAT_POS) begin
            r = 1'b1;
        end
        if (ext && pos == ppfm_pkg::PC_ERR_POS) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Combinational pin resolution
    // ---------------------------------------------------------------
    ppfm_pkg::ppfm_drive_t b_drv [B_PINS];
    ppfm_pkg::ppfm_drive_t c_drv [C_PINS];
    ppfm_pkg::ppfm_drive_t d_drv [D_PINS];

    // Port B cells
    for (genvar i = 0; i < B_PINS; i++) begin : g_b
        ppfm_pkg::ppfm_gpio_t g;
        logic mval;
        logic moe;
        assign g.data = b_data_i[i];
        assign g.dir = b_dir_i[i];
        // open drain only on upper bits
        assign g.od = (i >= ppfm_pkg::PB_OD_LO) ? b_od_i[i] : 1'b0;
        assign mval = b_group_sel_i[i] ? macrocell_group_two_i[i] : macrocell_group_one_i[i];
        assign moe = b_group_sel_i[i] ? macrocell_group_two_oe_i[i]
                                      : macrocell_group_one_oe_i[i];
        ppfm_pin_cell u_cell (
            .func_i(b_func_i[i]),
            .gpio_i(g),
            .pld_val_i(mval),
            .pld_oe_i(moe),
            .spc_val_i(1'b0),
            .spc_oe_i(1'b0),
            .drive_o(b_drv[i])
        );
    end

    // Port C cells
    for (genvar i = 0; i < C_PINS; i++) begin : g_c
        ppfm_pkg::ppfm_gpio_t g;
        logic spc;
        logic sval;
        logic soe;
        ppfm_pkg::ppfm_func_t fn;
        // dedicated functions override only while enabled
        assign spc = c_special(i, test_port_en_i, test_port_ext_en_i, ready_busy_en_i);
        assign fn = spc ? ppfm_pkg::PPFM_FN_SPECIAL
                        : (c_func_i[i] == ppfm_pkg::PPFM_FN_SPECIAL ? ppfm_pkg::PPFM_FN_PLD_IN
                                                                 : c_func_i[i]);
        assign g.data = c_data_i[i];
        assign g.dir = c_dir_i[i];
        // per-pin open drain in general I/O only
        assign g.od = (fn == ppfm_pkg::PPFM_FN_GPIO) ? c_od_i[i] : 1'b0;
        always_comb begin
            sval = 1'b0;
            soe = 1'b0;
            if (i == ppfm_pkg::PC_TDO_POS) begin
                sval = test_data_out_i;
                soe = test_data_out_oe_i;
            end else if (i == ppfm_pkg::PC_STAT_POS) begin
                // status, or ready/busy low while busy
                sval = test_port_ext_en_i ? test_port_status_i : ~flash_busy_i;
                soe = 1'b1;
            end else if (i == ppfm_pkg::PC_ERR_POS) begin
                sval = test_port_error_i;
                soe = 1'b1;
            end
        end
        ppfm_pin_cell u_cell (
            .func_i(fn),
            .gpio_i(g),
            .pld_val_i(macrocell_group_two_i[i]),
            .pld_oe_i(macrocell_group_two_oe_i[i]),
            .spc_val_i(sval),
            .spc_oe_i(soe),
            .drive_o(c_drv[i])
        );
    end

    // Port D cells
    for (genvar i = 0; i < D_PINS; i++) begin : g_d
        ppfm_pkg::ppfm_gpio_t g;
        logic in_only;
        ppfm_pkg::ppfm_func_t fn;
        assign in_only = (i == ppfm_pkg::PD_CLK_POS && logic_clk_en_i) ||
                         (i == ppfm_pkg::PD_CSI_POS && flash_cs_en_i);
        assign fn = in_only ? ppfm_pkg::PPFM_FN_PLD_IN
                            : (d_func_i[i] == ppfm_pkg::PPFM_FN_SPECIAL
                               ? ppfm_pkg::PPFM_FN_PLD_IN : d_func_i[i]);
        assign g.data = d_data_i[i];
        assign g.dir = d_dir_i[i];
        assign g.od = 1'b0;
        ppfm_pin_cell u_cell (
            .func_i(fn),
            .gpio_i(g),
            .pld_val_i(ext_cs_term_i[i]),
            .pld_oe_i(ext_cs_oe_i[i]),
            .spc_val_i(1'b0),
            .spc_oe_i(1'b0),
            .drive_o(d_drv[i])
        );
    end

    // ---------------------------------------------------------------
    // Registered outputs
    // ---------------------------------------------------------------
    logic [B_PINS-1:0] b_out_next, b_oen_next, b_fast_next;
    logic [C_PINS-1:0] c_out_next, c_oen_next;
    logic [D_PINS-1:0] d_out_next, d_oen_next;
    logic [B_PINS-1:0] b_out_reg, b_oen_reg, b_fast_reg, b_rd_reg;
    logic [C_PINS-1:0] c_out_reg, c_oen_reg, c_rd_reg;
    logic [D_PINS-1:0] d_out_reg, d_oen_reg, d_rd_reg;
    logic [2:0] tp_reg, tp_next;
    logic clk_reg, clk_next, csn_reg, csn_next, fen_reg, fen_next;

    // Next values of all pin drives and dedicated inputs
    always_comb begin
        for (int i = 0; i < B_PINS; i++) begin
            b_out_next[i] = b_drv[i].out;
            b_oen_next[i] = b_drv[i].oe_n;
            b_fast_next[i] = (i <= ppfm_pkg::PB_SLEW_HI) ? b_fast_i[i] : ppfm_pkg::SLEW_RST;
        end
        for (int i = 0; i < C_PINS; i++) begin
            c_out_next[i] = c_drv[i].out;
            c_oen_next[i] = c_drv[i].oe_n;
        end
        for (int i = 0; i < D_PINS; i++) begin
            d_out_next[i] = d_drv[i].out;
            d_oen_next[i] = d_drv[i].oe_n;
        end
        // test-port inputs, idle low when unselected
        tp_next = test_port_en_i ? {third_port_pins_i[ppfm_pkg::PC_TDI_POS],
                                    third_port_pins_i[ppfm_pkg::PC_TCK_POS],
                                    third_port_pins_i[ppfm_pkg::PC_TMS_POS]} : 3'h0;
        clk_next = logic_clk_en_i & fourth_port_pins_i[ppfm_pkg::PD_CLK_POS];
        // flash disabled while select is high
        csn_next = flash_cs_en_i ? fourth_port_pins_i[ppfm_pkg::PD_CSI_POS] : 1'b0;
        fen_next = ~csn_next;
    end

    // Register stage; pins float during reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            b_out_reg <= '0;
            b_oen_reg <= '1;
            b_fast_reg <= '0;
            b_rd_reg <= '0;
            c_out_reg <= '0;
            c_oen_reg <= '1;
            c_rd_reg <= '0;
            d_out_reg <= '0;
            d_oen_reg <= '1;
            d_rd_reg <= '0;
            tp_reg <= 3'h0;
            clk_reg <= 1'b0;
            csn_reg <= 1'b1;
            fen_reg <= 1'b0;
        end else begin
            b_out_reg <= b_out_next;
            b_oen_reg <= b_oen_next;
            b_fast_reg <= b_fast_next;
            // host samples pins; same values feed logic inputs
            b_rd_reg <= second_port_pins_i;
            c_rd_reg <= third_port_pins_i;
            d_rd_reg <= fourth_port_pins_i;
            c_out_reg <= c_out_next;
            c_oen_reg <= c_oen_next;
            d_out_reg <= d_out_next;
            d_oen_reg <= d_oen_next;
            tp_reg <= tp_next;
            clk_reg <= clk_next;
            csn_reg <= csn_next;
            fen_reg <= fen_next;
        end
    end

    // Output wiring straight from flip-flops
    assign second_port_pins_o = b_out_reg;
    assign second_port_pins_oe_n_o = b_oen_reg;
    assign second_port_fast_o = b_fast_reg;
    assign third_port_pins_o = c_out_reg;
    assign third_port_pins_oe_n_o = c_oen_reg;
    assign fourth_port_pins_o = d_out_reg;
    assign fourth_port_pins_oe_n_o = d_oen_reg;
    assign b_read_o = b_rd_reg;
    assign c_read_o = c_rd_reg;
    assign d_read_o = d_rd_reg;
    // input macrocells for B and C, direct path for D
    assign b_input_mcell_o = b_rd_reg;
    assign c_input_mcell_o = c_rd_reg;
    assign d_logic_in_o = d_rd_reg;
    assign test_mode_sel_o = tp_reg[0];
    assign test_clk_o = tp_reg[1];
    assign test_data_in_o = tp_reg[2];
    assign logic_clock_input_o = clk_reg;
    assign flash_cs_n_o = csn_reg;
    assign flash_enable_o = fen_reg;

endmodule // ppfm_top

`default_nettype wire

/* dv/ppfm_top_props.sv */
`default_nettype none

// -----------------------------------------------
// Pin mux checker
// -----------------------------------------------
module ppfm_top_props (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Controls and sources
    input wire logic test_port_en_i,
    input wire logic test_port_ext_en_i,
    input wire logic ready_busy_en_i,
    input wire logic logic_clk_en_i,
    input wire logic flash_cs_en_i,
    input wire logic [7:0] b_fast_i,
    input wire logic test_data_out_i,
    input wire logic test_data_out_oe_i,
    input wire logic test_port_status_i,
    input wire logic test_port_error_i,
    input wire logic flash_busy_i,
    input wire logic [7:0] third_port_pins_i,
    input wire logic [2:0] fourth_port_pins_i,
    // Observed outputs
    input wire logic [7:0] second_port_fast_o,
    input wire logic [7:0] third_port_pins_o,
    input wire logic [7:0] third_port_pins_oe_n_o,
    input wire logic [2:0] d_logic_in_o,
    input wire logic test_mode_sel_o,
    input wire logic test_clk_o,
    input wire logic test_data_in_o,
    input wire logic logic_clock_input_o,
    input wire logic flash_cs_n_o,
    input wire logic flash_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Status owns bit 3 over ready/busy, so ready/busy needs ext off
    sequence s_rb_sel;
        ready_busy_en_i && !test_port_ext_en_i;
    endsequence

    a_flash_sel: assert property (flash_cs_en_i |=>
        flash_cs_n_o == $past(fourth_port_pins_i[2]) && flash_enable_o == !flash_cs_n_o)
        else $error("flash select mismatch");
    a_logic_clk: assert property (logic_clk_en_i |=>
        logic_clock_input_o == $past(fourth_port_pins_i[1])) else $error("logic clock mismatch");
    a_test_in: assert property (test_port_en_i |=>
        {test_mode_sel_o, test_clk_o, test_data_in_o}
        == $past({third_port_pins_i[0], third_port_pins_i[1], third_port_pins_i[5]}))
        else $error("test port inputs mismatch");
    a_test_out: assert property (test_port_en_i && test_data_out_oe_i |=>
        !third_port_pins_oe_n_o[6] && third_port_pins_o[6] == $past(test_data_out_i))
        else $error("test out mismatch");
    a_ext_status: assert property (test_port_ext_en_i |=>
        third_port_pins_oe_n_o[4:3] == 2'h0
        && third_port_pins_o[4:3] == $past({test_port_error_i, test_port_status_i}))
        else $error("status pins mismatch");
    a_ready_busy: assert property (s_rb_sel |=>
        !third_port_pins_oe_n_o[3] && third_port_pins_o[3] == !$past(flash_busy_i))
        else $error("ready flag mismatch");
    a_slew_sel: assert property (1'b1 |=>
        second_port_fast_o == {4'h0, $past(b_fast_i[3:0])}) else $error("slew select mismatch");
    a_d_direct: assert property (1'b1 |=>
        d_logic_in_o == $past(fourth_port_pins_i)) else $error("port d input mismatch");
endmodule // ppfm_top_props

bind ppfm_top ppfm_top_props u_props (.ref_clk_i, .rst_b_i, .test_port_en_i, .test_port_ext_en_i,
    .ready_busy_en_i, .logic_clk_en_i, .flash_cs_en_i, .b_fast_i, .test_data_out_i,
    .test_data_out_oe_i, .test_port_status_i, .test_port_error_i, .flash_busy_i,
    .third_port_pins_i, .fourth_port_pins_i, .second_port_fast_o, .third_port_pins_o,
    .third_port_pins_oe_n_o, .d_logic_in_o, .test_mode_sel_o, .test_clk_o, .test_data_in_o,
    .logic_clock_input_o, .flash_cs_n_o, .flash_enable_o);

`default_nettype wire

/* dv/ppfm_host_model.sv */
`default_nettype none

// -----------------------------------------------
// Host and board side of the pads
// -----------------------------------------------
module ppfm_host_model (
    // Design drive
    input wire logic [7:0] b_o_i,
    input wire logic [7:0] b_oe_n_i,
    input wire logic [7:0] c_o_i,
    input wire logic [7:0] c_oe_n_i,
    input wire logic [2:0] d_o_i,
    input wire logic [2:0] d_oe_n_i,
    // Host line levels
    input wire logic [7:0] b_ext_i,
    input wire logic [7:0] c_ext_i,
    input wire logic [2:0] d_ext_i,
    // Pad levels
    output logic [7:0] b_pad_o,
    output logic [7:0] c_pad_o,
    output logic [2:0] d_pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // host drives lines the device leaves released
    assign b_pad_o = (b_oe_n_i & b_ext_i) | (~b_oe_n_i & b_o_i);
    assign c_pad_o = (c_oe_n_i & c_ext_i) | (~c_oe_n_i & c_o_i);
    assign d_pad_o = (d_oe_n_i & d_ext_i) | (~d_oe_n_i & d_o_i);
endmodule // ppfm_host_model

`default_nettype wire

/* dv/ppfm_top_tb.sv */
`default_nettype none

// -----------------------------------------------
// Pin mux testbench
// -----------------------------------------------
module ppfm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, rst_b_i;
    ppfm_pkg::ppfm_func_t b_func_i [8];
    ppfm_pkg::ppfm_func_t c_func_i [8];
    ppfm_pkg::ppfm_func_t d_func_i [3];
    logic [7:0] b_group_sel_i, b_data_i, b_dir_i, b_od_i, b_fast_i, c_data_i, c_dir_i, c_od_i;
    logic [7:0] macrocell_group_one_i, macrocell_group_one_oe_i, b_ext, c_ext;
    logic [7:0] macrocell_group_two_i, macrocell_group_two_oe_i;
    logic [2:0] d_data_i, d_dir_i, ext_cs_term_i, ext_cs_oe_i, d_ext;
    logic test_port_en_i, test_port_ext_en_i, ready_busy_en_i, logic_clk_en_i, flash_cs_en_i;
    logic test_data_out_i, test_data_out_oe_i, test_port_status_i, test_port_error_i;
    logic flash_busy_i, test_mode_sel_o, test_clk_o, test_data_in_o;
    logic logic_clock_input_o, flash_cs_n_o, flash_enable_o;
    logic [7:0] second_port_pins_i, second_port_pins_o, second_port_pins_oe_n_o;
    logic [7:0] second_port_fast_o, third_port_pins_i, third_port_pins_o, third_port_pins_oe_n_o;
    logic [7:0] b_read_o, c_read_o, b_input_mcell_o, c_input_mcell_o;
    logic [2:0] fourth_port_pins_i, fourth_port_pins_o, fourth_port_pins_oe_n_o;
    logic [2:0] d_read_o, d_logic_in_o;
    int miscompares = 0;
    int compares = 0;

    ppfm_top dut (.ref_clk_i, .rst_b_i, .b_func_i, .c_func_i, .d_func_i, .b_group_sel_i,
        .test_port_en_i, .test_port_ext_en_i, .ready_busy_en_i, .logic_clk_en_i,
        .flash_cs_en_i, .b_data_i, .b_dir_i, .b_od_i, .b_fast_i, .c_data_i, .c_dir_i, .c_od_i,
        .d_data_i, .d_dir_i, .macrocell_group_one_i, .macrocell_group_one_oe_i,
        .macrocell_group_two_i, .macrocell_group_two_oe_i, .ext_cs_term_i, .ext_cs_oe_i,
        .test_data_out_i, .test_data_out_oe_i, .test_port_status_i, .test_port_error_i,
        .flash_busy_i, .second_port_pins_i, .second_port_pins_o, .second_port_pins_oe_n_o,
        .second_port_fast_o, .third_port_pins_i, .third_port_pins_o, .third_port_pins_oe_n_o,
        .fourth_port_pins_i, .fourth_port_pins_o, .fourth_port_pins_oe_n_o, .b_read_o,
        .c_read_o, .d_read_o, .b_input_mcell_o, .c_input_mcell_o, .d_logic_in_o,
        .test_mode_sel_o, .test_clk_o, .test_data_in_o, .logic_clock_input_o, .flash_cs_n_o,
        .flash_enable_o);

    ppfm_host_model u_host (.b_o_i(second_port_pins_o), .b_oe_n_i(second_port_pins_oe_n_o),
        .c_o_i(third_port_pins_o), .c_oe_n_i(third_port_pins_oe_n_o),
        .d_o_i(fourth_port_pins_o), .d_oe_n_i(fourth_port_pins_oe_n_o), .b_ext_i(b_ext),
        .c_ext_i(c_ext), .d_ext_i(d_ext), .b_pad_o(second_port_pins_i),
        .c_pad_o(third_port_pins_i), .d_pad_o(fourth_port_pins_i));

    // Clock, 50 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Three edges: output register, pad settle, readback register
    task automatic step();
        repeat (3) @(posedge ref_clk_i);
        #5;
    endtask

    task automatic setf(input ppfm_pkg::ppfm_func_t f, input int port);
        for (int i = 0; i < 8; i++) begin
            if (port == 0) b_func_i[i] = f;
            if (port == 1) c_func_i[i] = f;
            if (port == 2 && i < 3) d_func_i[i] = f;
        end
    endtask

    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog, far beyond the roughly fifty cycles the tests need
    initial begin
        #100us;
        miscompares++;
        results();
    end

    initial begin
        {b_group_sel_i, b_data_i, b_dir_i, b_od_i, b_fast_i, c_data_i, c_dir_i, c_od_i} = '0;
        {macrocell_group_one_i, macrocell_group_one_oe_i, b_ext, c_ext} = '0;
        {macrocell_group_two_i, macrocell_group_two_oe_i, d_data_i, d_dir_i} = '0;
        {ext_cs_term_i, ext_cs_oe_i, d_ext, test_port_en_i, test_port_ext_en_i} = '0;
        {ready_busy_en_i, logic_clk_en_i, flash_cs_en_i, test_data_out_i} = '0;
        {test_data_out_oe_i, test_port_status_i, test_port_error_i, flash_busy_i} = '0;
        rst_b_i = 1'b0;
        for (int p = 0; p < 3; p++) setf(ppfm_pkg::PPFM_FN_GPIO, p);
        repeat (5) @(posedge ref_clk_i);
        #5;
        chk("b_oe_n", 8'hff, second_port_pins_oe_n_o);
        chk("flash", 8'h01, {6'h0, flash_enable_o, flash_cs_n_o});
        rst_b_i = 1'b1;
        $display("reset test done");
        // Port B general I/O with open drain and slew
        {b_dir_i, b_data_i, b_od_i, b_fast_i, b_ext} = {8'hff, 8'ha5, 8'hff, 8'hff, 8'hff};
        step();
        chk("b_oe_n", 8'ha0, second_port_pins_oe_n_o);
        chk("b_out", 8'h05, second_port_pins_o & ~second_port_pins_oe_n_o);
        chk("b_fast", 8'h0f, second_port_fast_o);
        chk("b_read", 8'ha5, b_read_o);
        // Port B logic outputs from both groups
        setf(ppfm_pkg::PPFM_FN_PLD_OUT, 0);
        {b_od_i, b_group_sel_i, macrocell_group_one_i, macrocell_group_two_i} = 32'h000f33c5;
        {macrocell_group_one_oe_i, macrocell_group_two_oe_i} = 16'hffff;
        step();
        chk("b_grp", 8'h35, second_port_pins_o);
        chk("b_oe_n", 8'h00, second_port_pins_oe_n_o);
        macrocell_group_one_oe_i = 8'h00;
        step();
        chk("b_oe_n", 8'hf0, second_port_pins_oe_n_o);
        setf(ppfm_pkg::PPFM_FN_SPECIAL, 0);
        step();
        chk("b_oe_n", 8'hff, second_port_pins_oe_n_o);
        setf(ppfm_pkg::PPFM_FN_PLD_IN, 0);
        b_ext = 8'h5a;
        step();
        chk("b_mcell", 8'h5a, b_input_mcell_o);
        $display("port b test done");
        // Port C open drain per pin, then group two
        {c_dir_i, c_data_i, c_od_i} = {8'hff, 8'hff, 8'h0f};
        step();
        chk("c_oe_n", 8'h0f, third_port_pins_oe_n_o);
        chk("c_read", 8'hf0, c_read_o);
        setf(ppfm_pkg::PPFM_FN_PLD_OUT, 1);
        {macrocell_group_two_i, macrocell_group_two_oe_i} = 16'h96ff;
        step();
        chk("c_grp", 8'h96, third_port_pins_o);
        $display("port c test done");
        // Test port, status, ready flag
        setf(ppfm_pkg::PPFM_FN_PLD_IN, 1);
        {c_ext, test_port_en_i, test_data_out_i, test_data_out_oe_i} = 11'h11f;
        step();
        chk("c_mcell", 8'h63, c_input_mcell_o);
        chk("tp_in", 8'h07, {5'h0, test_mode_sel_o, test_clk_o, test_data_in_o});
        chk("tdo", 8'h01, {6'h0, third_port_pins_oe_n_o[6], third_port_pins_o[6]});
        test_port_en_i = 1'b0;
        step();
        chk("tp_off", 8'h08, {4'h0, third_port_pins_oe_n_o[6], test_mode_sel_o,
            test_clk_o, test_data_in_o});
        {test_port_ext_en_i, test_port_status_i, test_port_error_i} = 3'h6;
        step();
        chk("stat", 8'h01, {4'h0, third_port_pins_oe_n_o[4:3], third_port_pins_o[4:3]});
        {test_port_ext_en_i, ready_busy_en_i, flash_busy_i} = 3'h3;
        step();
        chk("busy", 8'h00, {6'h0, third_port_pins_oe_n_o[3], third_port_pins_o[3]});
        flash_busy_i = 1'b0;
        step();
        chk("ready", 8'h01, {6'h0, third_port_pins_oe_n_o[3], third_port_pins_o[3]});
        $display("port c special test done");
        // Port D chip-select term, clock and flash select
        setf(ppfm_pkg::PPFM_FN_PLD_OUT, 2);
        {ext_cs_term_i, ext_cs_oe_i} = 6'h2f;
        step();
        chk("d_cs", 8'h05, {2'h0, fourth_port_pins_oe_n_o, fourth_port_pins_o});
        setf(ppfm_pkg::PPFM_FN_PLD_IN, 2);
        {d_ext, logic_clk_en_i, flash_cs_en_i} = 5'h0b;
        step();
        chk("d_in", 8'h02, {5'h0, d_logic_in_o});
        chk("clk", 8'h01, {7'h0, logic_clock_input_o});
        chk("csi_lo", 8'h02, {6'h0, flash_enable_o, flash_cs_n_o});
        d_ext = 3'h6;
        step();
        chk("csi_hi", 8'h01, {6'h0, flash_enable_o, flash_cs_n_o});
        // Dedicated inputs released, port D back to general I/O
        {logic_clk_en_i, flash_cs_en_i, d_dir_i, d_data_i} = 8'h3d;
        setf(ppfm_pkg::PPFM_FN_GPIO, 2);
        step();
        chk("d_gpio", 8'h05, {2'h0, fourth_port_pins_oe_n_o, fourth_port_pins_o});
        chk("d_read", 8'h05, {5'h0, d_read_o});
        chk("csi_off", 8'h02, {6'h0, flash_enable_o, flash_cs_n_o});
        $display("port d test done");
        results();
    end
endmodule // ppfm_top_tb

`default_nettype wire
